// *** rtl/reset_strap_config_loader.sv ***
`timescale 1ns/1ps
module reset_strap_config_loader
  import strap_cfg_pkg::*;
#(
  parameter int hold_cycles = strap_hold_cycles,
  parameter int depth       = cfg_depth
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic [1:0]            mclk_strap,
  input  wire logic                  out0_enable_strap,
  input  wire logic                  out1_enable_strap,
  input  wire logic [2:0]            misc_strap,
  input  wire logic                  otp_valid,
  input  wire logic [cfg_width-1:0]  otp_data,
  input  wire logic                  otp_programmed,
  output logic [addr_width-1:0]      otp_addr,
  input  wire logic                  host_write,
  input  wire logic                  host_read,
  input  wire logic [addr_width-1:0] host_addr,
  input  wire logic [cfg_width-1:0]  host_wdata,
  output logic [cfg_width-1:0]       host_rdata,
  output logic                       host_ack,
  output logic                       load_done,
  output logic                       ref_differential,
  output logic                       output_clock_zero_enable,
  output logic                       output_clock_one_enable,
  output logic [1:0]                 mclk_select,
  output logic                       mclk_reserved,
  output logic [2:0]                 misc_straps
);

  typedef enum logic [2:0] {
    st_load = 3'b001,
    st_wait = 3'b010,
    st_run  = 3'b100
  } state_t;

  state_t                state;
  logic [cfg_width-1:0]  store [depth];
  logic                  sample_now;
  logic                  taken;
  logic [addr_width-1:0] load_index;
  logic                  host_accept;
  logic                  write_accept;
  logic [cfg_width-1:0]  next_rdata;

  ////////////////////////////////////////////////////////////////////////
  // strap window counted in cycles of the 100 MHz clock input
  strap_sampler #(.hold_cycles(hold_cycles)) sampler (
    .clock      (clock),
    .reset      (reset),
    .sample_now (sample_now),
    .taken      (taken)
  );

  // built-in default per register
  function automatic logic [cfg_width-1:0] default_value(input logic [addr_width-1:0] a);
    default_value = (a == reference_input_config) ? ref_config_reset : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strap capture, once at window end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mclk_select   <= mclk_sel_24m576;
      mclk_reserved <= 1'b0;
      misc_straps   <= 3'b000;
    end else if (sample_now) begin
      mclk_select   <= mclk_strap;
      mclk_reserved <= !mclk_strap[1];
      misc_straps   <= misc_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // load sequence, then host access
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state      <= st_load;
      load_index <= 8'h00;
    end else begin
      case (state)
        st_load: begin
          if (otp_valid) begin
            if (load_index == 8'(depth - 1)) begin
              state <= st_wait;
            end else begin
              load_index <= load_index + 8'h01;
            end
          end
        end
        st_wait: begin
          if (taken) begin
            state <= st_run;
          end
        end
        st_run: begin
          state <= st_run;
        end
        default: state <= st_load;
      endcase
    end
  end

  // otp word address steps with each accepted word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      otp_addr <= 8'h00;
    end else if (state == st_load && otp_valid) begin
      otp_addr <= load_index + 8'h01;
    end
  end

  // load finished: all words stored and straps taken
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      load_done <= 1'b0;
    end else if (state == st_wait && taken) begin
      load_done <= 1'b1;
    end
  end

  // host requests count only once loading has finished
  always_comb begin
    host_accept  = (state == st_run) && (host_write || host_read);
    write_accept = (state == st_run) && host_write;
  end

  // store writes: defaults/otp during load, host afterwards
  always_ff @(posedge clock) begin
    if (state == st_load && otp_valid) begin
      store[load_index] <= otp_programmed ? otp_data : default_value(load_index);
    end else if (write_accept && host_addr < 8'(depth)) begin
      store[host_addr] <= host_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference mode: single-ended until the host asks otherwise
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ref_differential <= 1'b0;
    end else if (write_accept && host_addr == reference_input_config) begin
      ref_differential <= host_wdata[ref_diff_bit];
    end
  end

  // output enables: pull defaults, then straps, then host control
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      output_clock_zero_enable <= 1'b0;
      output_clock_one_enable  <= 1'b1;
    end else if (sample_now) begin
      output_clock_zero_enable <= out0_enable_strap;
      output_clock_one_enable  <= out1_enable_strap;
    end else if (write_accept && host_addr == out_enable_reg) begin
      output_clock_zero_enable <= host_wdata[out0_enable_bit];
      output_clock_one_enable  <= host_wdata[out1_enable_bit];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read value; status and strap codes readable before the load ends
  always_comb begin
    next_rdata = 8'h00;
    case (host_addr)
      load_status_reg: begin
        next_rdata[load_done_bit]    = load_done;
        next_rdata[straps_taken_bit] = taken;
      end
      master_select_reg: begin
        if (mclk_reserved) begin
          next_rdata = mclk_code_reserved;
        end else if (mclk_select == mclk_sel_20mhz) begin
          next_rdata = mclk_code_20mhz;
        end else begin
          next_rdata = mclk_code_24m576;
        end
      end
      out_enable_reg: begin
        next_rdata[out0_enable_bit] = output_clock_zero_enable;
        next_rdata[out1_enable_bit] = output_clock_one_enable;
      end
      reference_input_config: begin
        next_rdata[ref_diff_bit] = ref_differential;
      end
      default: begin
        if (state == st_run && host_addr < 8'(depth)) begin
          next_rdata = store[host_addr];
        end
      end
    endcase
  end

  // host read port; ack withheld until loading ends, read data latched on every read
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      host_rdata <= 8'h00;
      host_ack   <= 1'b0;
    end else begin
      host_ack <= host_accept;
      if (host_read) begin
        host_rdata <= next_rdata;
      end
    end
  end
endmodule

// *** rtl/strap_cfg_pkg.sv ***
package strap_cfg_pkg;
  localparam int          clock_mhz          = 100;
  localparam int          strap_hold_ms      = 55;
  localparam int          strap_hold_cycles  = strap_hold_ms * 1000 * clock_mhz;
  localparam int          cfg_depth          = 253;
  localparam int          cfg_width          = 8;
  localparam int          addr_width         = 8;
  localparam logic [7:0]  reference_input_config = 8'h0a;
  localparam logic [7:0]  out_enable_reg     = 8'h0b;
  localparam logic [7:0]  master_select_reg  = 8'h0c;
  localparam logic [7:0]  load_status_reg    = 8'h0d;
  localparam int          ref_diff_bit       = 0;
  localparam int          out0_enable_bit    = 0;
  localparam int          out1_enable_bit    = 1;
  localparam int          load_done_bit      = 0;
  localparam int          straps_taken_bit   = 1;
  localparam logic [7:0]  ref_config_reset   = 8'h00;
  localparam logic [1:0]  mclk_sel_20mhz     = 2'b10;
  localparam logic [1:0]  mclk_sel_24m576    = 2'b11;
  localparam logic [7:0]  mclk_code_reserved = 8'h00;
  localparam logic [7:0]  mclk_code_20mhz    = 8'h01;
  localparam logic [7:0]  mclk_code_24m576   = 8'h02;
  localparam int          out0_default_khz   = 25000;
  localparam int          out1_default_khz   = 125000;
  localparam int          out_max_khz        = 177500;
  localparam int          num_outputs        = 2;
endpackage

// *** rtl/strap_sampler.sv ***
`timescale 1ns/1ps
module strap_sampler
  import strap_cfg_pkg::*;
#(
  parameter int hold_cycles = strap_hold_cycles
) (
  input  wire logic clock,
  input  wire logic reset,
  output logic      sample_now,
  output logic      taken
);
  logic [31:0] count;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count      <= 32'h0000_0000;
      sample_now <= 1'b0;
      taken      <= 1'b0;
    end else begin
      sample_now <= 1'b0;
      if (!taken) begin
        if (count == 32'(hold_cycles - 1)) begin
          sample_now <= 1'b1;
          taken      <= 1'b1;
        end else begin
          count <= count + 32'h0000_0001;
        end
      end
    end
  end
endmodule

// *** test/reset_strap_config_loader_sva.sv ***
`timescale 1ns/1ps
module loader_sva
  import strap_cfg_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic                  host_write,
  input wire logic                  host_read,
  input wire logic [addr_width-1:0] host_addr,
  input wire logic [cfg_width-1:0]  host_wdata,
  input wire logic                  host_ack,
  input wire logic                  load_done,
  input wire logic                  ref_differential,
  input wire logic [1:0]            mclk_select,
  input wire logic [2:0]            misc_straps,
  input wire logic                  otp_valid,
  input wire logic [addr_width-1:0] otp_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_req;
    load_done && (host_read || host_write);
  endsequence
  sequence s_ref_wr;
    load_done && host_write && host_addr == reference_input_config;
  endsequence
  a_reset_values: assert property ($fell(reset) |-> !load_done && mclk_select == 2'b11)
    else $error("outputs left reset state early");
  a_req_acked: assert property (s_req |=> host_ack)
    else $error("host request not acknowledged");
  a_ack_cause: assert property (host_ack |-> $past(load_done) &&
    ($past(host_read) || $past(host_write)))
    else $error("acknowledge without request in run");
  a_ref_write: assert property (s_ref_wr |=> ref_differential == $past(host_wdata[0]))
    else $error("reference mode not applied");
  a_ref_cause: assert property ($changed(ref_differential) |->
    $past(load_done) && $past(host_write) && $past(host_addr) == reference_input_config)
    else $error("reference mode changed without write");
  a_straps_held: assert property (load_done |=>
    $stable(mclk_select) && $stable(misc_straps))
    else $error("latched straps changed");
  a_done_holds: assert property (load_done |=> load_done)
    else $error("load done dropped");
  a_otp_step: assert property (!load_done && otp_valid && otp_addr < 8'hfd |=>
    otp_addr == $past(otp_addr) + 8'h01)
    else $error("otp address did not advance");
endmodule
bind reset_strap_config_loader loader_sva i_loader_sva (.clock, .reset, .host_write, .host_read,
  .host_addr, .host_wdata, .host_ack, .load_done, .ref_differential, .mclk_select, .misc_straps,
  .otp_valid, .otp_addr);

// *** test/otp_model.sv ***
`timescale 1ns/1ps
module otp_model
  import strap_cfg_pkg::*;
(
  input  wire logic [addr_width-1:0] otp_addr,
  input  wire logic                  clock,
  output logic                       otp_valid,
  output logic [cfg_width-1:0]       otp_data,
  output logic                       otp_programmed
);
  // word ready every other cycle, garbage while not ready
  initial otp_valid = 1'b0;
  always @(posedge clock) otp_valid <= #1 ~otp_valid;
  assign otp_data = otp_valid ? otp_addr ^ 8'h5a : ~(otp_addr ^ 8'h5a);
  assign otp_programmed = otp_addr != reference_input_config;
endmodule

// *** test/tb_reset_strap_config_loader.sv ***
`timescale 1ns/1ps
module tb_reset_strap_config_loader;
  import strap_cfg_pkg::*;
  logic       clock, reset, out0_enable_strap, out1_enable_strap, otp_valid, otp_programmed;
  logic       host_write, host_read, host_ack, load_done, ref_differential, mclk_reserved;
  logic       output_clock_zero_enable, output_clock_one_enable;
  logic [1:0] mclk_strap, mclk_select;
  logic [2:0] misc_strap, misc_straps;
  logic [7:0] otp_data, otp_addr, host_addr, host_wdata, host_rdata;
  int         fail_count = 0;
  int         cmp_count = 0;
  reset_strap_config_loader #(.hold_cycles(20)) i_reset_strap_config_loader (
    .clock, .reset, .mclk_strap, .out0_enable_strap, .out1_enable_strap, .misc_strap,
    .otp_valid, .otp_data, .otp_programmed, .otp_addr, .host_write, .host_read, .host_addr,
    .host_wdata, .host_rdata, .host_ack, .load_done, .ref_differential, .output_clock_zero_enable,
    .output_clock_one_enable, .mclk_select, .mclk_reserved, .misc_straps);
  otp_model i_otp_model (.clock, .otp_addr, .otp_valid, .otp_data, .otp_programmed);
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clock) #1;
    host_addr = a;
    host_wdata = d;
    host_write = wr;
    host_read = !wr;
    @(posedge clock) #1;
    while (host_ack !== 1'b1 && n < 4) begin
      n++;
      @(posedge clock) #1;
    end
    host_write = 0;
    host_read = 0;
    chk("host_ack", 8'h01, 8'(host_ack));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    chk("host_rdata", e, host_rdata);
  endtask
  task automatic boot(input int k);
    int n = 0;
    reset = 1;
    mclk_strap = k[1:0];
    out0_enable_strap = k[0];
    out1_enable_strap = !k[1];
    misc_strap = k[2:0] ^ 3'h5;
    repeat (6) @(posedge clock);
    #1;
    chk("mclk_select", 8'h03, 8'(mclk_select));
    chk("out0 reset", 8'h00, 8'(output_clock_zero_enable));
    chk("out1 reset", 8'h01, 8'(output_clock_one_enable));
    reset = 0;
    host_write = 1;
    host_addr = reference_input_config;
    host_wdata = 8'h01;
    @(posedge clock) #1;
    host_write = 0;
    chk("early ack", 8'h00, 8'(host_ack));
    repeat (25) @(posedge clock) #1;
    mclk_strap = ~mclk_strap;
    out0_enable_strap = ~out0_enable_strap;
    out1_enable_strap = ~out1_enable_strap;
    misc_strap = ~misc_strap;
    while (load_done !== 1'b1 && n < 1000) begin
      n++;
      @(posedge clock) #1;
    end
    chk("load_done", 8'h01, 8'(load_done));
    chk("early write", 8'h00, 8'(ref_differential));
    chk("mclk_reserved", 8'(!k[1]), 8'(mclk_reserved));
    if (k[1]) chk("mclk_select", 8'(k[1:0]), 8'(mclk_select));
    chk("out0", 8'(k[0]), 8'(output_clock_zero_enable));
    chk("out1", 8'(!k[1]), 8'(output_clock_one_enable));
    chk("misc", 8'(k[2:0] ^ 3'h5), 8'(misc_straps));
    rd(master_select_reg, k[1] ? (k[0] ? mclk_code_24m576 : mclk_code_20mhz) : 8'h00);
    rd(8'h21, 8'h7b);
  endtask
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    host_read = 0;
    host_write = 0;
    host_addr = 8'h00;
    host_wdata = 0;
    for (int k = 0; k < 4; k++) boot(k);
    chk("ref_differential", 8'h00, 8'(ref_differential));
    rd(reference_input_config, ref_config_reset);
    rd(8'h20, 8'h7a);
    rd(8'hfc, 8'ha6);
    bus(1, reference_input_config, 8'h01);
    chk("ref_differential", 8'h01, 8'(ref_differential));
    bus(1, 8'h20, 8'hc3);
    rd(8'h20, 8'hc3);
    rd(load_status_reg, 8'h03);
    bus(1, 8'hfd, 8'hff);
    rd(8'hfd, 8'h00);
    bus(1, out_enable_reg, 8'h02);
    chk("out0", 8'h00, 8'(output_clock_zero_enable));
    chk("out1", 8'h01, 8'(output_clock_one_enable));
    rd(out_enable_reg, 8'h02);
    tally_and_finish;
  end
endmodule
